// File: fpt_totaliser.sv
// Purpose: pulse-counting flow rate and totaliser with integrity alarm
// Assumes: pulse and key inputs synchronous to sys_clk
// Notes: one shared serial divider serves interpolation, rate and filter
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fpt_totaliser #(
	parameter int GATE_CYC = fpt_pkg::GATE_CYC,
	parameter int BANNER_CYC = fpt_pkg::BANNER_CYC,
	parameter int PULSE_CYC = fpt_pkg::PULSE_CYC,
	parameter int PULSE_PER_CYC = fpt_pkg::PULSE_PER_CYC,
	parameter int FLASH_CYC = fpt_pkg::FLASH_CYC
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ch1_in,
	input wire logic ch2_in,
	input wire logic key_rate,
	input wire logic key_total,
	input wire logic key_display,
	input wire logic key_reset,
	input wire logic power_fail,
	input wire logic nv_restore,
	input wire logic [19:0] nv_acc_in,
	input wire logic [19:0] nv_res_in,
	output logic nv_save,
	output logic [19:0] nv_acc_out,
	output logic [19:0] nv_res_out,
	output logic alarm_n,
	output logic pulse_out_n,
	output logic [1:0] disp_sel,
	output logic disp_err13,
	output logic lamp_rate,
	output logic lamp_total,
	output logic flow_reverse,
	output logic [31:0] rate_out
);
	localparam int N = fpt_pkg::CORR_PTS;

	logic [4:0] ctrl_reg;
	logic [15:0] scale_reg;
	logic [7:0] filt_reg;
	logic [15:0] totdiv_reg;
	logic [15:0] cfreq_reg [N];
	logic [15:0] cfac_reg [N];
	logic [31:0] rate_reg;
	logic [15:0] freq_reg;
	logic [15:0] scale_now_reg;
	logic [19:0] res_reg;
	logic [19:0] acc_reg;
	logic alarm_reg;
	logic rev_reg;
	logic ovr_reg;
	fpt_pkg::fpt_disp_t disp_reg;
	fpt_pkg::fpt_calc_t calc_reg;
	logic ch1_q, ch2_q, kr_q, kt_q, kd_q, kx_q, pf_q;
	logic ch1_rise, ch2_rise, kr_p, kt_p, kd_p, kx_p;
	logic quad, wr_en, rd_en, map_hit;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Edge detection of pulses and keys
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			{ch1_q, ch2_q, kr_q, kt_q, kd_q, kx_q, pf_q} <= 7'h00;
		end else begin
			{ch1_q, ch2_q, kr_q, kt_q, kd_q, kx_q, pf_q} <=
				{ch1_in, ch2_in, key_rate, key_total, key_display, key_reset, power_fail};
		end
	end
	assign ch1_rise = ch1_in & ~ch1_q;
	assign ch2_rise = ch2_in & ~ch2_q;
	assign kr_p = key_rate & ~kr_q;
	assign kt_p = key_total & ~kt_q;
	assign kd_p = key_display & ~kd_q;
	assign kx_p = key_reset & ~kx_q;
	assign quad = ctrl_reg[fpt_pkg::CTRL_QUAD];

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states; read data registered in the setup cycle
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	always_comb begin
		rd_mux = 32'h0;
		map_hit = 1'b1;
		case (paddr)
			fpt_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl_reg};
			fpt_pkg::OFS_SCALE: rd_mux = {16'h0, scale_reg};
			fpt_pkg::OFS_FILT: rd_mux = {24'h0, filt_reg};
			fpt_pkg::OFS_TOTDIV: rd_mux = {16'h0, totdiv_reg};
			fpt_pkg::OFS_STATUS: rd_mux = {26'h0, disp_reg, 1'b0, ovr_reg, rev_reg, alarm_reg};
			fpt_pkg::OFS_RATE: rd_mux = rate_reg;
			fpt_pkg::OFS_RESTOT: rd_mux = {12'h0, res_reg};
			fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER: rd_mux = {12'h0, acc_reg};
			fpt_pkg::OFS_FREQ: rd_mux = {16'h0, freq_reg};
			default: begin
				map_hit = 1'b0;
				for (int i = 0; i < N; i++) begin
					if (paddr == fpt_pkg::OFS_CORR + 8'(4 * i)) begin
						map_hit = 1'b1;
						// Last point always reads 0 Hz
						rd_mux = {cfac_reg[i], (i == N - 1) ? 16'h0 : cfreq_reg[i]};
					end
				end
			end
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			prdata <= rd_en ? rd_mux : 32'h0;
			pslverr <= ~map_hit;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_reg <= 5'h00;
			scale_reg <= fpt_pkg::SCALE_RST;
			filt_reg <= fpt_pkg::FILT_RST;
			totdiv_reg <= fpt_pkg::TOTDIV_RST;
		end else if (wr_en) begin
			case (paddr)
				fpt_pkg::OFS_CTRL: ctrl_reg <= pwdata[4:0];
				fpt_pkg::OFS_SCALE: scale_reg <= pwdata[15:0];
				fpt_pkg::OFS_FILT: filt_reg <= pwdata[7:0];
				fpt_pkg::OFS_TOTDIV: totdiv_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end
	generate
		for (genvar g = 0; g < N; g++) begin : g_corr
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					cfreq_reg[g] <= 16'h0;
					cfac_reg[g] <= fpt_pkg::SCALE_RST;
				end else if (wr_en && paddr == fpt_pkg::OFS_CORR + 8'(4 * g)) begin
					cfreq_reg[g] <= pwdata[15:0];
					cfac_reg[g] <= pwdata[31:16];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Frequency gate and direction
	logic [31:0] gate_cnt;
	logic [15:0] fcnt;
	logic gate_tick;
	assign gate_tick = (gate_cnt == 32'(GATE_CYC - 1));
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gate_cnt <= 32'h0;
			fcnt <= 16'h0;
			freq_reg <= 16'h0;
			ovr_reg <= 1'b0;
		end else begin
			gate_cnt <= gate_tick ? 32'h0 : gate_cnt + 32'h1;
			if (gate_tick) begin
				freq_reg <= fcnt;
				fcnt <= 16'(ch1_rise);
				// Above the supported rate the figures are not trusted
				ovr_reg <= quad ? (fcnt > 16'(fpt_pkg::F_MAX_QUAD))
					: (fcnt > 16'(fpt_pkg::F_MAX_SINGLE));
			end else if (ch1_rise && fcnt != 16'hffff) begin
				fcnt <= fcnt + 16'h1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rev_reg <= 1'b0;
		end else if (quad && ch2_rise) begin
			rev_reg <= ~ch1_in; // Channel one high at reference edge means forward
		end
	end
	assign flow_reverse = rev_reg;

	////////////////////////////////////////////////////////////////////////
	// Integrity alarm
	logic [31:0] cnt1, cnt2, cdiff, cmax;
	assign cdiff = (cnt1 > cnt2) ? cnt1 - cnt2 : cnt2 - cnt1;
	assign cmax = (cnt1 > cnt2) ? cnt1 : cnt2;
	logic mism;
	// One pulse of skew is inherent to the 90 degree offset, so it never alarms
	assign mism = quad && cdiff > 32'h1
		&& 64'(cdiff) * 64'(fpt_pkg::MISMATCH_PPT) > 64'(cmax);
	always_ff @(posedge sys_clk) begin
		if (srst || kd_p || !quad) begin
			cnt1 <= 32'h0;
			cnt2 <= 32'h0;
		end else begin
			if (ch1_rise) cnt1 <= cnt1 + 32'h1;
			if (ch2_rise) cnt2 <= cnt2 + 32'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			alarm_reg <= 1'b0;
		end else if (mism && !kd_p) begin
			alarm_reg <= 1'b1;
		end else if (kd_p) begin
			alarm_reg <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) alarm_n <= 1'b1;
		else alarm_n <= ~alarm_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Factor selection, shared divider and calculation sequence
	logic sel_int;
	logic [15:0] sel_fac, sel_df, sel_dx, sel_base;
	logic [15:0] sel_span;
	logic sel_up;
	always_comb begin
		logic done;
		done = 1'b0;
		sel_int = 1'b0;
		sel_fac = scale_reg;
		sel_df = 16'h0;
		sel_dx = 16'h0;
		sel_base = scale_reg;
		sel_span = 16'h1;
		sel_up = 1'b0;
		if (ctrl_reg[fpt_pkg::CTRL_CORR] && cfreq_reg[0] != 16'h0) begin
			sel_fac = cfac_reg[0];
			done = (freq_reg >= cfreq_reg[0]); // First factor held above
			for (int i = 0; i < N - 1; i++) begin
				if (!done) begin
					if (i == N - 2 || cfreq_reg[i + 1] == 16'h0) begin
						sel_fac = cfac_reg[i]; // Table ends at 0 Hz
						done = 1'b1;
					end else if (freq_reg >= cfreq_reg[i + 1]) begin
						sel_int = 1'b1;
						sel_base = cfac_reg[i + 1];
						sel_up = cfac_reg[i] >= cfac_reg[i + 1];
						sel_df = sel_up ? cfac_reg[i] - cfac_reg[i + 1]
							: cfac_reg[i + 1] - cfac_reg[i];
						sel_dx = freq_reg - cfreq_reg[i + 1];
						sel_span = cfreq_reg[i] - cfreq_reg[i + 1];
						done = 1'b1;
					end
				end
			end
		end
	end

	logic [31:0] dq, dd;
	logic [32:0] dr, dtmp;
	logic [5:0] dcnt;
	logic dgo;
	logic [31:0] dnum, dden;
	logic dbusy;
	assign dbusy = (dcnt != 6'h0);
	assign dtmp = {dr[31:0], dq[31]};
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dq <= 32'h0;
			dd <= 32'h1;
			dr <= 33'h0;
			dcnt <= 6'h0;
		end else if (dgo) begin
			dq <= dnum;
			dd <= (dden == 32'h0) ? 32'h1 : dden;
			dr <= 33'h0;
			dcnt <= 6'd32;
		end else if (dbusy) begin
			dcnt <= dcnt - 6'h1;
			if (dtmp >= {1'b0, dd}) begin
				dr <= dtmp - {1'b0, dd};
				dq <= {dq[30:0], 1'b1};
			end else begin
				dr <= dtmp;
				dq <= {dq[30:0], 1'b0};
			end
		end
	end

	logic [16:0] tb_mul;
	logic [31:0] fdiff;
	logic fneg;
	always_comb begin
		case (ctrl_reg[fpt_pkg::CTRL_TB +: 2])
			2'd0: tb_mul = fpt_pkg::TB_SEC;
			2'd1: tb_mul = fpt_pkg::TB_MIN;
			2'd2: tb_mul = fpt_pkg::TB_HOUR;
			default: tb_mul = fpt_pkg::TB_DAY;
		endcase
	end
	logic [31:0] rate_raw;
	assign fneg = rate_raw < rate_reg;
	assign fdiff = fneg ? rate_reg - rate_raw : rate_raw - rate_reg;
	logic int_up;
	logic [15:0] int_base;
	always_comb begin
		dgo = 1'b0;
		dnum = 32'h0;
		dden = 32'h1;
		case (calc_reg)
			fpt_pkg::FPT_C_IDLE: begin
				if (gate_tick && sel_int) begin
					dgo = 1'b1;
					dnum = 32'(sel_df) * 32'(sel_dx);
					dden = 32'(sel_span);
				end else if (gate_tick) begin
					dgo = 1'b1;
					dnum = 32'(64'(freq_reg) * 64'(tb_mul));
					dden = 32'(sel_fac);
				end
			end
			fpt_pkg::FPT_C_INT: begin
				if (!dbusy) begin
					dgo = 1'b1;
					dnum = 32'(64'(freq_reg) * 64'(tb_mul));
					dden = int_up ? 32'(int_base) + dq : 32'(int_base) - dq;
				end
			end
			fpt_pkg::FPT_C_RATE: begin
				if (!dbusy && filt_reg > 8'h1) begin
					dgo = 1'b1;
					dnum = (dq < rate_reg) ? rate_reg - dq : dq - rate_reg;
					dden = 32'(filt_reg);
				end
			end
			default: ;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			calc_reg <= fpt_pkg::FPT_C_IDLE;
			scale_now_reg <= fpt_pkg::SCALE_RST;
			int_up <= 1'b0;
			int_base <= 16'h0;
			rate_raw <= 32'h0;
			rate_reg <= 32'h0;
		end else begin
			case (calc_reg)
				fpt_pkg::FPT_C_IDLE: begin
					if (gate_tick) begin
						calc_reg <= sel_int ? fpt_pkg::FPT_C_INT : fpt_pkg::FPT_C_RATE;
						int_up <= sel_up;
						int_base <= sel_base;
						if (!sel_int) scale_now_reg <= (sel_fac == 16'h0) ? 16'h1 : sel_fac;
					end
				end
				fpt_pkg::FPT_C_INT: begin
					if (!dbusy) begin
						scale_now_reg <= int_up ? int_base + dq[15:0] : int_base - dq[15:0];
						calc_reg <= fpt_pkg::FPT_C_RATE;
					end
				end
				fpt_pkg::FPT_C_RATE: begin
					if (!dbusy) begin
						rate_raw <= dq;
						if (filt_reg <= 8'h1) begin
							rate_reg <= dq; // Unfiltered
							calc_reg <= fpt_pkg::FPT_C_IDLE;
						end else begin
							calc_reg <= fpt_pkg::FPT_C_FILT;
						end
					end
				end
				fpt_pkg::FPT_C_FILT: begin
					if (!dbusy) begin
						// One A-th of the gap per update
						rate_reg <= fneg ? rate_reg - dq : rate_reg + dq;
						calc_reg <= fpt_pkg::FPT_C_IDLE;
					end
				end
				default: calc_reg <= fpt_pkg::FPT_C_IDLE;
			endcase
		end
	end
	assign rate_out = rate_reg; // Filtered rate also drives the analog path

	////////////////////////////////////////////////////////////////////////
	// Totals
	logic [31:0] pre_cnt, thr;
	logic tot_inc;
	assign thr = 32'(scale_now_reg) * 32'(totdiv_reg);
	// Frozen while alarmed, so pulses arriving during the alarm are not counted
	assign tot_inc = ch1_rise && !alarm_reg && (pre_cnt + 32'h1 >= thr);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pre_cnt <= 32'h0;
		end else if (ch1_rise && !alarm_reg) begin
			pre_cnt <= tot_inc ? 32'h0 : pre_cnt + 32'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			res_reg <= 20'h0;
			acc_reg <= 20'h0;
		end else if (nv_restore) begin
			res_reg <= nv_res_in;
			acc_reg <= nv_acc_in;
		end else begin
			if (kx_p) res_reg <= 20'h0; // Only the resettable total clears
			else if (tot_inc) res_reg <= (res_reg == fpt_pkg::TOT_MAX) ? 20'h0 : res_reg + 20'h1;
			if (tot_inc) acc_reg <= (acc_reg == fpt_pkg::TOT_MAX) ? 20'h0 : acc_reg + 20'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nv_save <= 1'b0;
			nv_acc_out <= 20'h0;
			nv_res_out <= 20'h0;
		end else begin
			nv_save <= power_fail & ~pf_q;
			nv_acc_out <= acc_reg;
			nv_res_out <= res_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pulse: backlog drains at no more than the allowed rate
	logic [7:0] pend;
	logic [31:0] pcnt;
	logic pstart;
	assign pstart = (pcnt == 32'h0) && (pend != 8'h0);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pend <= 8'h0;
		end else if (tot_inc && !pstart && pend != 8'hff) begin
			pend <= pend + 8'h1;
		end else if (pstart && !tot_inc) begin
			pend <= pend - 8'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pcnt <= 32'h0;
			pulse_out_n <= 1'b1;
		end else begin
			if (pstart) pcnt <= 32'h1;
			else if (pcnt != 32'h0) pcnt <= (pcnt == 32'(PULSE_PER_CYC - 1)) ? 32'h0 : pcnt + 32'h1;
			pulse_out_n <= ~(pstart || (pcnt != 32'h0 && pcnt < 32'(PULSE_CYC)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Display selection, banner and error flash
	logic [31:0] ban_cnt, fl_cnt;
	logic fl_ph;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			disp_reg <= fpt_pkg::FPT_D_RATE;
			ban_cnt <= 32'h0;
		end else begin
			case (disp_reg)
				fpt_pkg::FPT_D_BANNER: begin
					ban_cnt <= ban_cnt + 32'h1;
					if (ban_cnt == 32'(BANNER_CYC - 1)) disp_reg <= fpt_pkg::FPT_D_ACC;
				end
				default: ban_cnt <= 32'h0;
			endcase
			if (kr_p) disp_reg <= fpt_pkg::FPT_D_RATE;
			else if (kt_p) disp_reg <= fpt_pkg::FPT_D_TOTAL;
			else if (kd_p && (disp_reg == fpt_pkg::FPT_D_RATE
				|| disp_reg == fpt_pkg::FPT_D_TOTAL)) begin
				disp_reg <= fpt_pkg::FPT_D_BANNER;
				ban_cnt <= 32'h0;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst || !alarm_reg) begin
			fl_cnt <= 32'h0;
			fl_ph <= 1'b0;
		end else if (fl_cnt == 32'(FLASH_CYC - 1)) begin
			fl_cnt <= 32'h0;
			fl_ph <= ~fl_ph;
		end else begin
			fl_cnt <= fl_cnt + 32'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			disp_sel <= 2'h0;
			lamp_rate <= 1'b0;
			lamp_total <= 1'b0;
			disp_err13 <= 1'b0;
		end else begin
			disp_sel <= disp_reg;
			lamp_rate <= (disp_reg == fpt_pkg::FPT_D_RATE);
			lamp_total <= (disp_reg == fpt_pkg::FPT_D_TOTAL);
			disp_err13 <= alarm_reg & fl_ph;
		end
	end
endmodule

// File: fpt_pkg.sv
// Purpose: constants and types for the flow pulse totaliser
// Assumes: 100 MHz sys_clk, APB register access
// Notes: cycle counts derive from times
//
// Overview of operation
// - Two-channel: alarm if count difference exceeds 1 per 1000 pulses; the code never alarms on a difference of 1
// - Alarm freezes all totals at pre-alarm values
// - Alarm output low while alarm stands
// - Alarm flashes error code 13
// - Display key clears alarm, releases output, resumes totals
// - Channel one leads 90 degrees; phase order gives direction
// - Rate is frequency times timebase over scaling factor
// - Correction picks the factor for the measured frequency
// - Count up to 10 kHz single-channel, 2.5 kHz two-channel
// - Totals wrap to zero at display maximum
// - Totals saved on power loss, restored at power-up
// - First display press: banner one second, then accumulated total
// - Keys clear only the resettable total
// - Rate and total keys select display; lamp marks it
// - One output pulse per accumulated total increment
// - Output pulse is low for 10 ms
// - At most 49 output pulses per second
// - Programmable averaging filter smooths rate, also for analog out
// - Filter constant 1 passes rate unfiltered
// - Interpolate between points; first factor held above first point
// - A 0 Hz point ends the table; tenth is always 0 Hz
package fpt_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int GATE_MS = 1000;
	localparam int BANNER_MS = 1000;
	localparam int PULSE_MS = 10;
	localparam int FLASH_MS = 500;
	localparam int PULSE_PER_S = 49;
	localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
	localparam int BANNER_CYC = CLK_HZ / 1000 * BANNER_MS;
	localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
	localparam int FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
	localparam int PULSE_PER_CYC = (CLK_HZ + PULSE_PER_S - 1) / PULSE_PER_S;
	localparam int F_MAX_SINGLE = 10000;
	localparam int F_MAX_QUAD = 2500;
	localparam int MISMATCH_PPT = 1000;
	localparam int CORR_PTS = 10;
	localparam logic [19:0] TOT_MAX = 20'hf423f;
	localparam logic [16:0] TB_SEC = 17'h00001;
	localparam logic [16:0] TB_MIN = 17'h0003c;
	localparam logic [16:0] TB_HOUR = 17'h00e10;
	localparam logic [16:0] TB_DAY = 17'h15180;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SCALE = 8'h04;
	localparam logic [7:0] OFS_FILT = 8'h08;
	localparam logic [7:0] OFS_TOTDIV = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RATE = 8'h14;
	localparam logic [7:0] OFS_RESTOT = 8'h18;
	localparam logic [7:0] OFS_ACCUMULATED_TOTAL_BANNER = 8'h1c;
	localparam logic [7:0] OFS_FREQ = 8'h20;
	localparam logic [7:0] OFS_CORR = 8'h40;
	localparam int CTRL_QUAD = 0;
	localparam int CTRL_CORR = 1;
	localparam int CTRL_TB = 2;
	localparam int ST_ALARM = 0;
	localparam int ST_REV = 1;
	localparam int ST_OVR = 2;
	localparam int ST_DISP = 4;
	localparam int CORR_FAC = 16;
	localparam logic [15:0] SCALE_RST = 16'h0001;
	localparam logic [7:0] FILT_RST = 8'h01;
	localparam logic [15:0] TOTDIV_RST = 16'h0001;
	typedef enum logic [1:0] {FPT_D_RATE, FPT_D_TOTAL, FPT_D_BANNER, FPT_D_ACC} fpt_disp_t;
	typedef enum logic [1:0] {FPT_C_IDLE, FPT_C_INT, FPT_C_RATE, FPT_C_FILT} fpt_calc_t;
endpackage

// File: fpt_pulse_model.sv
// Purpose: two-channel pulse source in place of the flowmeter sensors
// Assumes: the bench calls one burst at a time, right after a rising edge
// Notes: lines idle low between bursts; each quarter period is 10 cycles
`timescale 1ns/1ps
module fpt_pulse_model (
	input wire logic sys_clk,
	output logic ch1_in,
	output logic ch2_in
);
	logic lead = 1'b0;
	logic lag = 1'b0;
	logic rev = 1'b0;
	logic drop = 1'b0;
	// Forward flow puts the leading phase on channel one
	assign ch1_in = rev ? lag : lead;
	// Dropping channel two pulses is the only fault any test asks for
	assign ch2_in = drop ? 1'b0 : (rev ? lead : lag);
	task automatic burst(input int n, input logic r, input logic d);
		for (int i = 0; i < 4 * n; i++) begin
			@(posedge sys_clk);
			rev <= r;
			drop <= d;
			lead <= (i % 4) < 2;
			lag <= (i % 4) == 1 || (i % 4) == 2;
			repeat (9) @(posedge sys_clk);
		end
	endtask
endmodule

// File: fpt_totaliser_assertions.sv
// Purpose: port-level checks on the flow pulse totaliser
// Assumes: one clock domain, srst synchronous and active high
// Notes: pulse, gap and banner lengths are measured by small counters
`timescale 1ns/1ps
module fpt_totaliser_assertions #(
	parameter int PULSE_CYC = 10,
	parameter int PULSE_PER_CYC = 25,
	parameter int BANNER_CYC = 50
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic key_display,
	input wire logic power_fail,
	input wire logic nv_restore,
	input wire logic nv_save,
	input wire logic [19:0] nv_acc_out,
	input wire logic alarm_n,
	input wire logic pulse_out_n,
	input wire logic [1:0] disp_sel,
	input wire logic disp_err13,
	input wire logic lamp_rate,
	input wire logic lamp_total
);
	int low_cnt_reg;
	int gap_cnt_reg;
	int ban_cnt_reg;
	logic pulse_d_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			low_cnt_reg <= 0;
			gap_cnt_reg <= 32'h00ff_ffff;
			ban_cnt_reg <= 0;
			pulse_d_reg <= 1'b1;
		end else begin
			low_cnt_reg <= pulse_out_n ? 0 : low_cnt_reg + 1;
			gap_cnt_reg <= (pulse_d_reg && !pulse_out_n) ? 1 : gap_cnt_reg + 1;
			ban_cnt_reg <= (disp_sel == 2'h2) ? ban_cnt_reg + 1 : 0;
			pulse_d_reg <= pulse_out_n;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Restore takes two edges to reach the copy, so those steps are exempt
	property acc_step_p;
		$changed(nv_acc_out) && !$past(nv_restore) && !$past(nv_restore, 2) |->
			nv_acc_out == (($past(nv_acc_out) == fpt_pkg::TOT_MAX) ? 20'h0 :
			$past(nv_acc_out) + 20'h1);
	endproperty
	chk_acc_step: assert property (acc_step_p)
		else $error("accumulated total stepped wrongly");
	chk_pulse_width: assert property ($rose(pulse_out_n) |-> low_cnt_reg == PULSE_CYC)
		else $error("output pulse width wrong");
	chk_pulse_gap: assert property (pulse_d_reg && !pulse_out_n |-> gap_cnt_reg >= PULSE_PER_CYC)
		else $error("output pulses too close");
	chk_total_freeze: assert property (!alarm_n && !$past(alarm_n) && !$past(alarm_n, 2) |-> $stable(nv_acc_out))
		else $error("total moved during alarm");
	chk_alarm_release: assert property ($rose(alarm_n) |-> $past(key_display) || $past(key_display, 2) || $past(key_display, 3))
		else $error("alarm released without display key");
	chk_err_flash: assert property (disp_err13 |-> !alarm_n || !$past(alarm_n))
		else $error("error code shown without alarm");
	chk_nv_save: assert property ($rose(power_fail) |-> ##[1:3] nv_save)
		else $error("no save on power loss");
	chk_lamp_select: assert property (!(lamp_rate && lamp_total))
		else $error("both lamps lit");
	chk_banner_len: assert property (ban_cnt_reg != 0 && disp_sel != 2'h2 |-> ban_cnt_reg >= BANNER_CYC && ban_cnt_reg <= BANNER_CYC + 1 && disp_sel == 2'h3)
		else $error("banner length or follow-up wrong");
	cover property ($fell(alarm_n));
	cover property ($rose(pulse_out_n));
	cover property (disp_sel == 2'h2 ##1 disp_sel == 2'h3);
	cover property (nv_save);
endmodule
bind fpt_totaliser fpt_totaliser_assertions #(
	.PULSE_CYC(PULSE_CYC), .PULSE_PER_CYC(PULSE_PER_CYC), .BANNER_CYC(BANNER_CYC)
) fpt_totaliser_assertions_i (
	.sys_clk(sys_clk), .srst(srst), .key_display(key_display), .power_fail(power_fail),
	.nv_restore(nv_restore), .nv_save(nv_save), .nv_acc_out(nv_acc_out), .alarm_n(alarm_n),
	.pulse_out_n(pulse_out_n), .disp_sel(disp_sel), .disp_err13(disp_err13),
	.lamp_rate(lamp_rate), .lamp_total(lamp_total)
);

// File: fpt_totaliser_tb.sv
// Purpose: self-checking bench for the flow pulse totaliser
// Assumes: shortened gate, banner, pulse and flash counts
// Notes: rate reads happen mid-burst
`timescale 1ns/1ps
module fpt_totaliser_tb;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ch1_in;
	logic ch2_in;
	logic [3:0] keys = 4'h0;
	logic power_fail = 1'b0;
	logic nv_restore = 1'b0;
	logic [19:0] nv_acc_in = 20'h0;
	logic [19:0] nv_res_in = 20'h0;
	logic nv_save;
	logic [19:0] nv_acc_out;
	logic [19:0] nv_res_out;
	logic alarm_n;
	logic pulse_out_n;
	logic [1:0] disp_sel;
	logic disp_err13;
	logic lamp_rate;
	logic lamp_total;
	logic flow_reverse;
	logic [31:0] rate_out;
	int failures = 0;
	int checked = 0;
	int pulses = 0;
	int flashes = 0;
	int saves = 0;
	int p0;
	int f0;
	logic pulse_d = 1'b1;
	logic err_d = 1'b0;
	logic [31:0] r;
	logic [31:0] f;
	logic [31:0] a0;
	logic e;
	logic [16:0] mult [4] = '{fpt_pkg::TB_SEC, fpt_pkg::TB_MIN, fpt_pkg::TB_HOUR, fpt_pkg::TB_DAY};
	always #5 sys_clk = ~sys_clk;
	fpt_totaliser #(.GATE_CYC(200), .BANNER_CYC(50), .PULSE_CYC(10), .PULSE_PER_CYC(25),
		.FLASH_CYC(20)) fpt_totaliser_i (
		.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch1_in(ch1_in), .ch2_in(ch2_in), .key_rate(keys[0]), .key_total(keys[1]),
		.key_display(keys[2]), .key_reset(keys[3]), .power_fail(power_fail),
		.nv_restore(nv_restore), .nv_acc_in(nv_acc_in), .nv_res_in(nv_res_in), .nv_save(nv_save),
		.nv_acc_out(nv_acc_out), .nv_res_out(nv_res_out), .alarm_n(alarm_n),
		.pulse_out_n(pulse_out_n), .disp_sel(disp_sel), .disp_err13(disp_err13),
		.lamp_rate(lamp_rate), .lamp_total(lamp_total), .flow_reverse(flow_reverse),
		.rate_out(rate_out));
	fpt_pulse_model fpt_pulse_model_i (.sys_clk(sys_clk), .ch1_in(ch1_in), .ch2_in(ch2_in));
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		pulse_d <= pulse_out_n;
		err_d <= disp_err13;
		if (pulse_d === 1'b1 && pulse_out_n === 1'b0)
			pulses <= pulses + 1;
		if (err_d === 1'b0 && disp_err13 === 1'b1)
			flashes <= flashes + 1;
		if (nv_save === 1'b1)
			saves <= saves + 1;
	end
	task automatic apb(input logic [7:0] a, input logic w = 1'b0, input logic [31:0] d = 32'h0);
		@(posedge sys_clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Key held one cycle, then settle
	task automatic press(input logic [3:0] k);
		@(posedge sys_clk);
		keys <= k;
		@(posedge sys_clk);
		keys <= 4'h0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic tally_and_finish();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		apb(fpt_pkg::OFS_SCALE);
		chk(r, 32'(fpt_pkg::SCALE_RST));
		apb(fpt_pkg::OFS_FILT);
		chk(r, 32'(fpt_pkg::FILT_RST));
		apb(fpt_pkg::OFS_TOTDIV);
		chk(r, 32'(fpt_pkg::TOTDIV_RST));
		apb(8'h24, 1'b1, 32'h5);
		chk(32'(e), 32'h1);
		apb(fpt_pkg::OFS_CORR + 8'h24, 1'b1, 32'h0005_1234);
		apb(fpt_pkg::OFS_CORR + 8'h24);
		chk(r, 32'h0005_0000);
		$display("test registers done");
		p0 = pulses;
		fpt_pulse_model_i.burst(6, 1'b0, 1'b0);
		repeat (30) @(posedge sys_clk);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		chk(r, 32'h6);
		chk(32'(pulses - p0), 32'h6);
		press(4'h8);
		apb(fpt_pkg::OFS_RESTOT);
		chk(r, 32'h0);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		chk(r, 32'h6);
		press(4'h1);
		chk({30'h0, lamp_rate, lamp_total}, 32'h2);
		chk(32'(disp_sel), 32'h0);
		press(4'h2);
		chk({30'h0, lamp_rate, lamp_total}, 32'h1);
		chk(32'(disp_sel), 32'h1);
		$display("test counting and keys done");
		nv_acc_in <= 20'hf423e;
		nv_res_in <= 20'h5;
		nv_restore <= 1'b1;
		@(posedge sys_clk);
		nv_restore <= 1'b0;
		fpt_pulse_model_i.burst(3, 1'b0, 1'b0);
		repeat (10) @(posedge sys_clk);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		chk(r, 32'h1);
		apb(fpt_pkg::OFS_RESTOT);
		chk(r, 32'h8);
		power_fail <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(32'(saves), 32'h1);
		chk(32'(nv_acc_out), 32'h1);
		power_fail <= 1'b0;
		$display("test rollover and storage done");
		apb(fpt_pkg::OFS_SCALE, 1'b1, 32'h64);
		for (int t = 0; t < 4; t++) begin
			apb(fpt_pkg::OFS_CTRL, 1'b1, {28'h0, 2'(t), 2'h0});
			fork
				fpt_pulse_model_i.burst(20, 1'b0, 1'b0);
				begin
					repeat (600) @(posedge sys_clk);
					apb(fpt_pkg::OFS_FREQ);
					f = r;
					apb(fpt_pkg::OFS_RATE);
					chk(r, 32'(64'(f) * 64'(mult[t]) / 64'h64));
				end
			join
		end
		apb(fpt_pkg::OFS_SCALE, 1'b1, 32'h1);
		$display("test rate done");
		apb(fpt_pkg::OFS_CTRL, 1'b1, 32'h1);
		fpt_pulse_model_i.burst(3, 1'b1, 1'b0);
		chk(32'(flow_reverse), 32'h1);
		fpt_pulse_model_i.burst(3, 1'b0, 1'b0);
		chk(32'(flow_reverse), 32'h0);
		chk(32'(alarm_n), 32'h1);
		$display("test direction done");
		fpt_pulse_model_i.burst(4, 1'b0, 1'b1);
		repeat (10) @(posedge sys_clk);
		chk(32'(alarm_n), 32'h0);
		apb(fpt_pkg::OFS_STATUS);
		chk(r & 32'h1, 32'h1);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		a0 = r;
		f0 = flashes;
		fpt_pulse_model_i.burst(3, 1'b0, 1'b0);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		chk(r, a0);
		chk(32'(flashes > f0), 32'h1);
		press(4'h4);
		chk(32'(alarm_n), 32'h1);
		chk(32'(disp_sel), 32'h2);
		repeat (60) @(posedge sys_clk);
		chk(32'(disp_sel), 32'h3);
		fpt_pulse_model_i.burst(5, 1'b0, 1'b0);
		repeat (20) @(posedge sys_clk);
		chk(32'(alarm_n), 32'h1);
		apb(fpt_pkg::OFS_ACCUMULATED_TOTAL_BANNER);
		chk(r, a0 + 32'h5);
		$display("test integrity alarm done");
		tally_and_finish();
	end
	// Tests take about 4500 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end
endmodule
